// File: pkg/rsp_pkg.sv
// constants and types for the rate sensor serial register port
package rsp_pkg;
    // frame layout
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned RW_BIT     = 15;
    localparam int unsigned ADDR_MSB   = 14;
    localparam int unsigned ADDR_LSB   = 8;
    localparam logic [4:0]  CNT_LAST   = 5'h0f;

    // byte address space: 0x00..0x3f mapped, 0x40..0x7f unmapped
    localparam int unsigned ADDR_W     = 7;
    localparam int unsigned IDX_W      = 5;
    localparam int unsigned UNMAP_BIT  = 6;

    // word indices (byte address divided by two)
    localparam logic [4:0]  IDX_FLASH_CNT  = 5'h00;
    localparam logic [4:0]  IDX_TEMP       = 5'h01;
    localparam logic [4:0]  IDX_RATE_LOWER = 5'h02;
    localparam logic [4:0]  IDX_RATE_UPPER = 5'h03;
    localparam logic [4:0]  IDX_FB_FIRST   = 5'h04;
    localparam logic [4:0]  IDX_MISC       = 5'h0e;
    localparam logic [4:0]  IDX_SMPL       = 5'h0f;
    localparam logic [4:0]  IDX_FILTER     = 5'h10;
    localparam logic [4:0]  IDX_DECIMATION = 5'h11;
    localparam logic [4:0]  IDX_FB_LAST    = 5'h12;
    localparam logic [4:0]  IDX_GLOBAL_CMD = 5'h14;

    // global_command byte fields
    localparam int unsigned BACKUP_BIT = 3;

    // field widths
    localparam int unsigned DEC_W    = 5;
    localparam int unsigned FILTER_W = 3;
    localparam logic [5:0]  WORD_BITS = 6'h10;

    // flash defaults after erase (power-on)
    localparam logic [15:0] DEF_ZERO = 16'h0000;
    localparam logic [15:0] DEF_MISC = 16'h0006;
    localparam logic [15:0] DEF_SMPL = 16'h000f;

    typedef enum logic [1:0] {NV_IDLE, NV_RELOAD, NV_BACKUP} rsp_nv_state_t;

    function automatic logic [15:0] rsp_default(input logic [4:0] idx);
        logic [15:0] v;
        v = DEF_ZERO;
        if (idx == IDX_MISC)
            v = DEF_MISC;
        else if (idx == IDX_SMPL)
            v = DEF_SMPL;
        return v;
    endfunction : rsp_default
endpackage : rsp_pkg

// File: pkg/rsp_nv_if.sv
// link between the register port and the flash mirror store
`timescale 1ns/10ps
`default_nettype none
interface rsp_nv_if;
    logic        backup_req;
    logic        busy;
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [15:0] wr_data;
    logic [4:0]  rd_idx;
    logic [15:0] rd_data;
    logic [15:0] flash_cnt;

    modport core  (output backup_req, rd_data,
                   input  busy, wr_en, wr_idx, wr_data, rd_idx, flash_cnt);
    modport store (input  backup_req, rd_data,
                   output busy, wr_en, wr_idx, wr_data, rd_idx, flash_cnt);
endinterface : rsp_nv_if
`default_nettype wire

// File: logic/rsp_nvstore.sv
// nonvolatile mirror of the flash-backed control words, reload and backup walker
`timescale 1ns/10ps
`default_nettype none
module rsp_nvstore
    import rsp_pkg::*;
(
    // clock and resets
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic por_n,
    // working memory side
    rsp_nv_if.store   nv
);
    logic [15:0]   flash_q [IDX_FB_FIRST:IDX_FB_LAST];
    logic [15:0]   cnt_q;
    rsp_nv_state_t state_q;
    logic [4:0]    idx_q;
    wire           at_last = (idx_q == IDX_FB_LAST);

    // flash keeps its contents across rstn; only power-on erases it
    always_ff @(posedge mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            for (int i = IDX_FB_FIRST; i <= IDX_FB_LAST; i++)
                flash_q[i] <= rsp_default(5'(i));
            cnt_q <= DEF_ZERO;
        end
        else if (state_q == NV_BACKUP)
        begin
            flash_q[idx_q] <= nv.rd_data;
            if (at_last)
                cnt_q <= cnt_q + 16'h0001;
        end
    end

    // every rstn reset starts a reload walk; a por_n reset alone does not
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= NV_RELOAD;
            idx_q   <= IDX_FB_FIRST;
        end
        else
        begin
            case (state_q)
                NV_IDLE:
                begin
                    idx_q <= IDX_FB_FIRST;
                    if (nv.backup_req)
                        state_q <= NV_BACKUP;
                end
                default:
                begin
                    // wrap at the end so the walker never points past the mirror
                    idx_q <= at_last ? IDX_FB_FIRST : idx_q + 5'h01;
                    if (at_last)
                        state_q <= NV_IDLE;
                end
            endcase
        end
    end

    assign nv.busy      = (state_q != NV_IDLE);
    assign nv.wr_en     = (state_q == NV_RELOAD);
    assign nv.wr_idx    = idx_q;
    assign nv.wr_data   = flash_q[idx_q];
    assign nv.rd_idx    = idx_q;
    assign nv.flash_cnt = cnt_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence backup_last;
        state_q == NV_BACKUP && at_last;
    endsequence

    chk_reload_ends: assert property (nv.wr_en && idx_q == IDX_FB_FIRST
        |-> nv.wr_en [*8] ##8 !nv.busy)
        else $error("reload walk did not cover all flash-backed words");
    chk_backup_copies: assert property (backup_last
        |=> flash_q[IDX_FB_LAST] == $past(nv.rd_data) && cnt_q == $past(cnt_q) + 16'h0001)
        else $error("backup did not store last word or count the write");
endmodule : rsp_nvstore
`default_nettype wire

// File: logic/rsp_top.sv
// serial register port of the rate sensor: spi slave, output words, working memory
`timescale 1ns/10ps
`default_nettype none
module rsp_top
    import rsp_pkg::*;
(
    // clock and resets
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        por_n,
    // spi pins
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    // sensor core
    input  wire logic        sample_valid,
    input  wire logic [15:0] rate_upper_in,
    input  wire logic [15:0] rate_lower_in,
    input  wire logic [15:0] temp_in,
    output logic             sample_done_pin,
    // configuration to the core
    output logic [4:0]       cfg_decimation,
    output logic [2:0]       cfg_filter,
    output logic [15:0]      cfg_sample_period
);
    rsp_nv_if nv ();

    rsp_nvstore rsp_nvstore_i (
        .mclk  (mclk),
        .rstn  (rstn),
        .por_n (por_n),
        .nv    (nv)
    );

    logic        sclk_q;
    logic        cs_q;
    logic [4:0]  bit_cnt_q;
    logic [14:0] rx_q;
    logic [15:0] tx_q;
    logic        dout_q;
    logic        dout_oe_q;
    logic        rd_pend_q;
    logic [6:0]  rd_addr_q;
    logic        backup_q;
    logic        sample_done_q;
    logic [15:0] rate_upper_q;
    logic [15:0] rate_lower_q;
    logic [15:0] temp_q;
    logic [15:0] work_q [IDX_FB_FIRST:IDX_FB_LAST];

    // sclk is slow against mclk, so edges are found by comparing with last value
    wire         active     = !cs_n;
    wire         rise       = sclk && !sclk_q;
    wire         fall       = !sclk && sclk_q;
    wire         cs_start   = !cs_n && cs_q;
    wire         frame_done = active && rise && (bit_cnt_q == CNT_LAST);
    // last bit comes straight from din on the completing edge
    wire  [15:0] frame_word = {rx_q, din};
    wire         is_write   = frame_word[RW_BIT];
    wire  [6:0]  wr_addr    = frame_word[ADDR_MSB:ADDR_LSB];
    wire  [7:0]  wr_byte    = frame_word[7:0];
    wire  [4:0]  wr_idx     = wr_addr[IDX_W:1];
    wire         wr_hi      = wr_addr[0];
    wire         wr_mapped  = !wr_addr[UNMAP_BIT];
    wire         wr_fb      = wr_mapped && wr_idx >= IDX_FB_FIRST && wr_idx <= IDX_FB_LAST;
    wire         wr_fire    = frame_done && is_write && wr_fb && !nv.busy;
    wire         wr_backup  = frame_done && is_write && wr_mapped && !wr_hi
                              && wr_idx == IDX_GLOBAL_CMD && wr_byte[BACKUP_BIT];

    // read selection
    wire  [4:0]  rd_idx    = rd_addr_q[IDX_W:1];
    wire         rd_mapped = !rd_addr_q[UNMAP_BIT];
    wire         rd_fb     = rd_idx >= IDX_FB_FIRST && rd_idx <= IDX_FB_LAST;
    logic [15:0] rd_word;

    always_comb
    begin
        rd_word = DEF_ZERO;
        if (!rd_mapped)
            rd_word = DEF_ZERO;
        else if (rd_idx == IDX_FLASH_CNT)
            rd_word = nv.flash_cnt;
        else if (rd_idx == IDX_TEMP)
            rd_word = temp_q;
        else if (rd_idx == IDX_RATE_LOWER)
            rd_word = rate_lower_q;
        else if (rd_idx == IDX_RATE_UPPER)
            rd_word = rate_upper_q;
        else if (rd_fb)
            rd_word = work_q[rd_idx];
    end

    // lower rate word keeps only as many top bits as the decimation setting
    wire  [4:0]  dec_set = work_q[IDX_DECIMATION][DEC_W-1:0];
    wire  [15:0] lower_mask;
    genvar b;
    generate
        for (b = 0; b < FRAME_BITS; b++)
        begin : g_mask
            assign lower_mask[b] = ({1'b0, dec_set} + 6'(b)) >= WORD_BITS;
        end
    endgenerate

    // edge history and serial shift registers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            // idle-high reset values keep a false edge away after reset
            sclk_q <= 1'b1;
            cs_q   <= 1'b1;
        end
        else
        begin
            sclk_q <= sclk;
            cs_q   <= cs_n;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_cnt_q <= 5'h00;
            rx_q      <= 15'h0000;
            tx_q      <= 16'h0000;
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
        end
        else if (!active)
        begin
            bit_cnt_q <= 5'h00;
            dout_oe_q <= 1'b0;
        end
        else if (cs_start)
        begin
            // first bit must stand before the first falling edge in mode 3
            bit_cnt_q <= 5'h00;
            dout_q    <= rd_word[15];
            tx_q      <= {rd_word[14:0], 1'b0};
            dout_oe_q <= rd_pend_q;
        end
        else if (rise)
        begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            rx_q      <= {rx_q[13:0], din};
        end
        else if (fall && bit_cnt_q != 5'h00)
        begin
            dout_q <= tx_q[15];
            tx_q   <= {tx_q[14:0], 1'b0};
        end
    end

    // request pipeline: a read taken now is answered in the next frame
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= 7'h00;
            backup_q  <= 1'b0;
        end
        else
        begin
            backup_q <= wr_backup && !nv.busy;
            if (frame_done)
            begin
                rd_pend_q <= !is_write;
                rd_addr_q <= wr_addr;
            end
            else if (cs_start)
                rd_pend_q <= 1'b0;
        end
    end

    // working copy; flash reload has the port while it runs
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = IDX_FB_FIRST; i <= IDX_FB_LAST; i++)
                work_q[i] <= DEF_ZERO;
        end
        else if (nv.wr_en)
            work_q[nv.wr_idx] <= nv.wr_data;
        else if (wr_fire && wr_hi)
            work_q[wr_idx][15:8] <= wr_byte;
        else if (wr_fire)
            work_q[wr_idx][7:0] <= wr_byte;
    end

    // output data words follow the core without any host action
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rate_upper_q  <= DEF_ZERO;
            rate_lower_q  <= DEF_ZERO;
            temp_q        <= DEF_ZERO;
            sample_done_q <= 1'b0;
        end
        else
        begin
            sample_done_q <= sample_valid;
            if (sample_valid)
            begin
                rate_upper_q <= rate_upper_in;
                rate_lower_q <= rate_lower_in & lower_mask;
                temp_q       <= temp_in;
            end
        end
    end

    assign nv.backup_req     = backup_q;
    assign nv.rd_data        = work_q[nv.rd_idx];
    assign dout              = dout_q;
    assign dout_oe           = dout_oe_q;
    assign sample_done_pin   = sample_done_q;
    assign cfg_decimation    = work_q[IDX_DECIMATION][DEC_W-1:0];
    assign cfg_filter        = work_q[IDX_FILTER][FILTER_W-1:0];
    assign cfg_sample_period = work_q[IDX_SMPL];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence lone_sample;
        sample_valid ##1 !sample_valid;
    endsequence

    sequence low_byte_write;
        wr_fire && !wr_hi;
    endsequence

    sequence high_byte_write;
        wr_fire && wr_hi;
    endsequence

    chk_oe_released: assert property (cs_n && $past(cs_n) |-> !dout_oe)
        else $error("dout enabled while chip select high");
    chk_oe_drop: assert property (!active |=> !dout_oe)
        else $error("dout still enabled after chip select rose");
    chk_cnt_clear: assert property (!active |=> bit_cnt_q == 5'h00)
        else $error("bit counter not cleared between frames");
    chk_no_drive_write: assert property (cs_start && !rd_pend_q |=> !dout_oe)
        else $error("dout enabled without preceding read frame");
    chk_read_answer: assert property (cs_start && rd_pend_q |=> dout_oe
        && dout == $past(rd_word[15]))
        else $error("read answer msb missing at frame start");
    chk_pipelined_read: assert property (frame_done && !is_write |=> rd_pend_q
        && rd_addr_q == $past(wr_addr))
        else $error("read request not captured for next frame");
    chk_rise_sample: assert property (active && rise && !cs_start |=> rx_q[0] == $past(din))
        else $error("input bit not sampled on rising edge");
    chk_fall_shift: assert property (active && fall && !cs_start && bit_cnt_q != 5'h00
        |=> dout == $past(tx_q[15]))
        else $error("output bit not shifted on falling edge");
    chk_done_pulse: assert property (lone_sample |-> sample_done_pin ##1 !sample_done_pin)
        else $error("sample done pulse not one cycle");
    chk_done_idle: assert property (!sample_valid |=> !sample_done_pin)
        else $error("sample done high without a sample");
    chk_byte_keep: assert property (low_byte_write |=> work_q[$past(wr_idx)][7:0]
        == $past(wr_byte) && work_q[$past(wr_idx)][15:8] == $past(work_q[wr_idx][15:8]))
        else $error("byte write disturbed the other byte");
    chk_byte_keep_hi: assert property (high_byte_write |=> work_q[$past(wr_idx)][15:8]
        == $past(wr_byte) && work_q[$past(wr_idx)][7:0] == $past(work_q[wr_idx][7:0]))
        else $error("high byte write disturbed the low byte");
    chk_lower_mask: assert property (sample_valid && dec_set == 5'h00 |=> rate_lower_q == 16'h0000)
        else $error("lower rate word not masked with zero decimation");
    chk_capture_words: assert property (sample_valid
        |=> rate_upper_q == $past(rate_upper_in) && temp_q == $past(temp_in))
        else $error("output words not captured from core");
    // host writes must never reach the core-owned words
    chk_words_hold: assert property (!sample_valid |=> $stable(rate_upper_q)
        && $stable(rate_lower_q) && $stable(temp_q))
        else $error("output words changed without a sample");
    chk_backup_cmd: assert property (wr_backup && !nv.busy |=> nv.backup_req ##1 nv.busy)
        else $error("backup command did not start flash backup");
    chk_backup_busy: assert property (wr_backup && nv.busy |=> !nv.backup_req)
        else $error("backup command taken while flash walker busy");
endmodule : rsp_top
`default_nettype wire

// File: tb/rsp_host_model.sv
// host side spi master model, mode 3, 16-bit frames
`timescale 1ns/10ps
`default_nettype none
module rsp_host_model
#(
    parameter int HALF_CYC  = 8,
    parameter int STALL_CYC = 600
)
(
    // clock
    input  wire logic mclk,
    // spi lines
    input  wire logic miso,
    input  wire logic miso_oe,
    output var logic  sclk,
    output var logic  cs_n,
    output var logic  din
);
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // oe counts the bit slots in which the device drove its output
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic [4:0] oe);
        rx = 16'h0000;
        oe = 5'h00;
        @(negedge mclk);
        cs_n = 1'b0;
        repeat (2) @(negedge mclk);
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b0;
            din  = tx[i];
            repeat (HALF_CYC) @(negedge mclk);
            rx[i] = miso;
            oe    = oe + {4'h0, miso_oe};
            sclk  = 1'b1;
            repeat (HALF_CYC) @(negedge mclk);
        end
        cs_n = 1'b1;
        // released line shows no stale bit
        din  = ~din;
        repeat (STALL_CYC) @(negedge mclk);
    endtask : frame
endmodule : rsp_host_model
`default_nettype wire

// File: tb/rsp_top_tb.sv
// self-checking bench for the rate sensor serial register port
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module rsp_top_tb;
    int          checks        = 0;
    int          bad_count     = 0;
    logic        mclk          = 1'b0;
    logic        rstn          = 1'b0;
    logic        por_n         = 1'b0;
    logic        sample_valid  = 1'b0;
    logic [15:0] rate_upper_in = 16'h0000;
    logic [15:0] rate_lower_in = 16'h0000;
    logic [15:0] temp_in       = 16'h0000;
    logic        miso_last     = 1'b0;
    wire         sclk;
    wire         cs_n;
    wire         din;
    wire         dout;
    wire         dout_oe;
    wire         sample_done_pin;
    wire  [4:0]  cfg_decimation;
    wire  [2:0]  cfg_filter;
    wire  [15:0] cfg_sample_period;
    // undriven line has no pull: show the inverse of its last level
    wire         miso = dout_oe ? dout : ~miso_last;

    always #12.5 mclk = ~mclk;

    always @(posedge mclk) miso_last <= (miso === 1'b1);

    rsp_top rsp_top_i (
        .mclk              (mclk),
        .rstn              (rstn),
        .por_n             (por_n),
        .sclk              (sclk),
        .cs_n              (cs_n),
        .din               (din),
        .dout              (dout),
        .dout_oe           (dout_oe),
        .sample_valid      (sample_valid),
        .rate_upper_in     (rate_upper_in),
        .rate_lower_in     (rate_lower_in),
        .temp_in           (temp_in),
        .sample_done_pin   (sample_done_pin),
        .cfg_decimation    (cfg_decimation),
        .cfg_filter        (cfg_filter),
        .cfg_sample_period (cfg_sample_period)
    );

    rsp_host_model rsp_host_model_i (
        .mclk    (mclk),
        .miso    (miso),
        .miso_oe (dout_oe),
        .sclk    (sclk),
        .cs_n    (cs_n),
        .din     (din)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic do_reset(input logic power);
        @(negedge mclk);
        rstn  = 1'b0;
        por_n = ~power;
        repeat (6) @(negedge mclk);
        rstn  = 1'b1;
        por_n = 1'b1;
        repeat (20) @(negedge mclk);
    endtask : do_reset

    task automatic sample(input logic [15:0] up, input logic [15:0] lo, input logic [15:0] tp);
        @(negedge mclk);
        rate_upper_in = up;
        rate_lower_in = lo;
        temp_in       = tp;
        sample_valid  = 1'b1;
        @(negedge mclk);
        sample_valid = 1'b0;
        `CHK(sample_done_pin, 1'b1)
        @(negedge mclk);
        `CHK(sample_done_pin, 1'b0)
    endtask : sample

    // one frame; the answer is compared only when the device should drive
    task automatic xfer(input logic [15:0] tx, input logic [15:0] exp, input logic [4:0] exp_oe);
        logic [15:0] rx;
        logic [4:0]  oe;
        rsp_host_model_i.frame(tx, rx, oe);
        `CHK(oe, exp_oe)
        if (exp_oe != 5'h00)
            `CHK(rx, exp)
        `CHK(dout_oe, 1'b0)
    endtask : xfer

    initial
    begin
        do_reset(1'b1);
        `CHK(cfg_sample_period, 16'h000f)
        `CHK(cfg_decimation, 5'h00)
        `CHK(cfg_filter, 3'h0)
        $display("test reset done");
        sample(16'h9fdf, 16'hffff, 16'hf165);
        xfer(16'h0600, 16'h0000, 5'h00);
        xfer(16'h0400, 16'h9fdf, 5'h10);
        xfer(16'h0200, 16'h0000, 5'h10);
        xfer(16'h4000, 16'hf165, 5'h10);
        xfer(16'h0000, 16'h0000, 5'h10);
        $display("test pipelined reads done");
        xfer(16'ha203, 16'h0000, 5'h10);
        `CHK(cfg_decimation, 5'h03)
        xfer(16'h2200, 16'h0000, 5'h00);
        xfer(16'h0400, 16'h0003, 5'h10);
        sample(16'h0001, 16'hffff, 16'h0001);
        xfer(16'h0000, 16'he000, 5'h10);
        $display("test decimation done");
        xfer(16'h9f12, 16'h0000, 5'h10);
        `CHK(cfg_sample_period, 16'h120f)
        xfer(16'h9e34, 16'h0000, 5'h00);
        `CHK(cfg_sample_period, 16'h1234)
        xfer(16'h8655, 16'h0000, 5'h00);
        xfer(16'h0600, 16'h0000, 5'h00);
        xfer(16'ha808, 16'h0001, 5'h10);
        $display("test byte writes done");
        xfer(16'ha205, 16'h0000, 5'h00);
        `CHK(cfg_decimation, 5'h05)
        xfer(16'ha004, 16'h0000, 5'h00);
        `CHK(cfg_filter, 3'h4)
        do_reset(1'b0);
        `CHK(cfg_decimation, 5'h03)
        `CHK(cfg_filter, 3'h0)
        `CHK(cfg_sample_period, 16'h1234)
        xfer(16'h0000, 16'h0000, 5'h00);
        xfer(16'h0000, 16'h0001, 5'h10);
        $display("test backup done");
        summarize();
    end

    // about 18 frames of some 860 cycles each fit well inside this span
    initial
    begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        summarize();
    end
endmodule : rsp_top_tb
`default_nettype wire
